// >>> rtl/asts_pkg.sv
package asts_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_MODE_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_MODE_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_CHAN_SEL = 8'h08;
    localparam logic [7:0] ADDR_RESULT_BASE = 8'h20;
    localparam int NUM_RESULTS = 8;
    localparam int NUM_SLOTS = 4;
    // mode_control_0 field positions
    localparam int POS_ENABLE = 0;
    localparam int POS_ACTIVE = 1;
    localparam int POS_MODE_LO = 2;
    localparam int POS_MODE_HI = 3;
    // mode_control_2 / channel select positions
    localparam int POS_BUF_MODE = 0;
    localparam int POS_CHAN_HI = 2;
    // operating_mode_field encodings
    localparam logic [1:0] MODE_CONT_SELECT = 2'h0;
    localparam logic [1:0] MODE_CONT_SCAN = 2'h1;
    localparam logic [1:0] MODE_ONESHOT_SELECT = 2'h2;
    localparam logic [1:0] MODE_ONESHOT_SCAN = 2'h3;
    // reset values and the last four-buffer slot
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic RST_BUF_MODE = 1'b0;
    localparam logic [2:0] RST_CHAN = 3'h0;
    localparam logic [2:0] LAST_SLOT = 3'h3;

    typedef enum logic [2:0] {
        ASTS_IDLE = 3'b001,
        ASTS_START = 3'b010,
        ASTS_WAIT = 3'b100
    } asts_state_t;
endpackage : asts_pkg

// >>> rtl/asts_sequencer.sv
`timescale 1ns/1ps
module asts_sequencer
    import asts_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic convStart,
    output logic convAbort,
    output logic [2:0] convChannel,
    input wire logic convDone,
    input wire logic [RES_W-1:0] convData,
    output logic convEndIrq,
    output logic convActive
);
    if (RES_W < 1 || RES_W > 32) begin : g_bad_width
        $error("RES_W must lie between 1 and 32");
    end

    typedef struct packed {
        asts_state_t state;
        logic enable;
        logic [1:0] mode;
        logic bufMode;
        logic [2:0] chan;
        logic [2:0] cnt;
        logic startPulse;
        logic abortPulse;
        logic irq;
        logic [2:0] channel;
        logic [31:0] rdata;
        logic [NUM_RESULTS-1:0][RES_W-1:0] result;
    } asts_regs_t;

    asts_regs_t s;
    asts_regs_t next_s;

    function automatic logic isScan(input logic [1:0] m);
        return m[0];
    endfunction : isScan

    // scan ignores the buffer bit, so four-buffer only exists in select
    function automatic logic isQuad(input logic [1:0] m, input logic b);
        return !m[0] && b;
    endfunction : isQuad

    logic hitM0;
    logic hitM2;
    logic hitCh;
    logic ctrlWrite;
    logic [2:0] storeIdx;
    logic lastConv;
    logic [2:0] rdIdx;

    assign hitM0 = regWr && regAddr == ADDR_MODE_CTRL0;
    assign hitM2 = regWr && regAddr == ADDR_MODE_CTRL2;
    assign hitCh = regWr && regAddr == ADDR_CHAN_SEL;
    assign ctrlWrite = hitM0 || hitM2 || hitCh;
    assign rdIdx = regAddr[4:2];

    always_comb begin
        if (isQuad(s.mode, s.bufMode)) begin
            storeIdx = s.cnt;
            lastConv = s.cnt == LAST_SLOT;
        end else if (isScan(s.mode)) begin
            storeIdx = s.cnt;
            lastConv = s.cnt == s.chan;
        end else begin
            storeIdx = s.chan;
            lastConv = 1'b1;
        end
    end

    always_comb begin
        next_s = s;
        next_s.startPulse = 1'b0;
        next_s.abortPulse = 1'b0;
        next_s.irq = 1'b0;
        next_s.rdata = 32'h0000_0000;

        if (regRd) begin
            if (regAddr == ADDR_MODE_CTRL0) begin
                next_s.rdata[POS_ENABLE] = s.enable;
                next_s.rdata[POS_ACTIVE] = s.state != ASTS_IDLE;
                next_s.rdata[POS_MODE_HI:POS_MODE_LO] = s.mode;
            end else if (regAddr == ADDR_MODE_CTRL2) begin
                next_s.rdata[POS_BUF_MODE] = s.bufMode;
            end else if (regAddr == ADDR_CHAN_SEL) begin
                next_s.rdata[POS_CHAN_HI:0] = s.chan;
            end else if (regAddr[7:5] == ADDR_RESULT_BASE[7:5] && regAddr[1:0] == 2'h0) begin
                next_s.rdata[RES_W-1:0] = s.result[rdIdx];
            end
        end

        unique case (s.state)
            ASTS_IDLE: begin
            end
            ASTS_START: begin
                next_s.startPulse = 1'b1;
                next_s.channel = isScan(s.mode) ? s.cnt : s.chan;
                next_s.state = ASTS_WAIT;
            end
            ASTS_WAIT: begin
                if (convDone && !ctrlWrite) begin
                    next_s.result[storeIdx] = convData;
                    next_s.irq = lastConv;
                    if (lastConv) begin
                        next_s.cnt = 3'h0;
                        if (s.mode[1]) begin
                            // one-shot end: software must set enable again
                            next_s.enable = 1'b0;
                            next_s.state = ASTS_IDLE;
                        end else begin
                            next_s.state = ASTS_START;
                        end
                    end else begin
                        next_s.cnt = s.cnt + 3'h1;
                        next_s.state = ASTS_START;
                    end
                end
            end
        endcase

        // a control write always wins over a completing conversion
        if (ctrlWrite) begin
            if (hitM0) begin
                next_s.enable = regWdata[POS_ENABLE];
                next_s.mode = regWdata[POS_MODE_HI:POS_MODE_LO];
            end
            if (hitM2) begin
                next_s.bufMode = regWdata[POS_BUF_MODE];
            end
            if (hitCh) begin
                next_s.chan = regWdata[POS_CHAN_HI:0];
            end
            next_s.abortPulse = s.state == ASTS_WAIT;
            // a start launched now would orphan a conversion the core never ends
            next_s.startPulse = 1'b0;
            next_s.cnt = 3'h0;
            if (next_s.enable) begin
                next_s.state = ASTS_START;
            end else begin
                next_s.state = ASTS_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s.state <= ASTS_IDLE;
            s.enable <= 1'b0;
            s.mode <= RST_MODE;
            s.bufMode <= RST_BUF_MODE;
            s.chan <= RST_CHAN;
            s.cnt <= 3'h0;
            s.startPulse <= 1'b0;
            s.abortPulse <= 1'b0;
            s.irq <= 1'b0;
            s.channel <= 3'h0;
            s.rdata <= 32'h0000_0000;
            s.result <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign regRdata = s.rdata;
    assign convStart = s.startPulse;
    assign convAbort = s.abortPulse;
    assign convChannel = s.channel;
    assign convEndIrq = s.irq;
    assign convActive = s.state != ASTS_IDLE;

    // plain net so the abort check can look one cycle back
    logic inWait;
    assign inWait = s.state == ASTS_WAIT;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    AST_ENABLE_STARTS: assert property (
        (hitM0 && regWdata[POS_ENABLE]) ##1 !regWr |-> ##1 convStart)
        else $error("enable write did not start a conversion");

    AST_ACTIVE_WHILE_CONV: assert property (
        (convStart || s.state == ASTS_WAIT) |-> convActive)
        else $error("active flag low during conversion");

    AST_WRITE_ABORTS: assert property (
        (ctrlWrite && s.state == ASTS_WAIT && next_s.enable) ##1 !ctrlWrite
            |-> convAbort ##1 convStart)
        else $error("control write did not abort and restart");

    AST_QUAD_SLOT0: assert property (
        (s.state == ASTS_WAIT && convDone && !ctrlWrite && isQuad(s.mode, s.bufMode)
            && s.cnt == 3'h0) |=> s.result[0] == $past(convData))
        else $error("first four-buffer result not in slot zero");

    AST_QUAD_IRQ: assert property (
        (convEndIrq && isQuad(s.mode, s.bufMode)) |-> $past(s.cnt) == LAST_SLOT)
        else $error("four-buffer irq before fourth conversion");

    AST_SCAN_RANGE: assert property (
        (convStart && isScan(s.mode)) |-> convChannel <= s.chan)
        else $error("scan converted beyond channel field");

    AST_ONESHOT_STOPS: assert property (
        (convEndIrq && s.mode[1] && !regWr) |-> !convActive [*2])
        else $error("one-shot sequence did not stop");

    AST_CONT_RESTART: assert property (
        (convEndIrq && !s.mode[1] && !regWr) |=> convStart && convChannel
            == (isScan(s.mode) ? 3'h0 : s.chan))
        else $error("continuous mode did not restart");

    AST_SEL1_IRQ: assert property (
        (s.state == ASTS_WAIT && convDone && !ctrlWrite && !isScan(s.mode)
            && !isQuad(s.mode, s.bufMode)) |=> convEndIrq && s.result[$past(s.chan)]
            == $past(convData))
        else $error("one-buffer select missed store or irq");

    AST_SELECT_CHANNEL: assert property (
        (inWait && !isScan(s.mode)) |-> convChannel == s.chan)
        else $error("select mode converting an input other than the field");

    AST_SCAN_SLOT_MATCH: assert property (
        (inWait && isScan(s.mode)) |-> convChannel == s.cnt)
        else $error("scan input and result slot disagree");

    AST_QUAD_ORDER: assert property (
        (inWait && convDone && !ctrlWrite && isQuad(s.mode, s.bufMode) && s.cnt != LAST_SLOT)
            |=> s.cnt == $past(s.cnt) + 3'h1 && !convEndIrq)
        else $error("four-buffer slot skipped or irq raised early");

    AST_QUAD_RANGE: assert property (
        (inWait && isQuad(s.mode, s.bufMode)) |-> s.cnt <= LAST_SLOT)
        else $error("four-buffer slot counter out of range");

    AST_SCAN_MID_NO_IRQ: assert property (
        (inWait && convDone && !ctrlWrite && isScan(s.mode) && s.cnt != s.chan)
            |=> !convEndIrq && s.cnt == $past(s.cnt) + 3'h1)
        else $error("scan raised irq before its last input");

    AST_SCAN_LAST_IRQ: assert property (
        (inWait && convDone && !ctrlWrite && isScan(s.mode) && s.cnt == s.chan)
            |=> convEndIrq && s.cnt == 3'h0)
        else $error("scan missed irq after its last input");

    AST_QUAD_STORE: assert property (
        (inWait && convDone && !ctrlWrite && !isScan(s.mode) && s.bufMode)
            |=> s.result[$past(s.cnt)] == $past(convData))
        else $error("four-buffer result not in its ordered slot");

    AST_SCAN_BUF1: assert property (
        (inWait && convDone && !ctrlWrite && isScan(s.mode) && s.bufMode)
            |=> s.result[$past(s.cnt)] == $past(convData)
            && convEndIrq == ($past(s.cnt) == s.chan))
        else $error("scan with buffer bit set did not keep one-buffer storage");

    AST_CONT_KEEPS_RUNNING: assert property (
        (convActive && !s.mode[1] && !ctrlWrite) |=> convActive)
        else $error("continuous mode stopped without enable clear");

    AST_CLEAR_IDLES: assert property (
        (hitM0 && !regWdata[POS_ENABLE]) |=> !convActive && !s.enable)
        else $error("enable clear left the sequencer active");

    AST_ONESHOT_CLEARS: assert property (
        (convEndIrq && s.mode[1]) |-> !convActive && !s.enable)
        else $error("one-shot end left enable or active set");

    AST_ABORT_ONLY_WAIT: assert property (
        convAbort |-> $past(inWait) && $past(ctrlWrite))
        else $error("abort pulse without a write during conversion");

    COV_QUAD_GROUP: cover property (convEndIrq && isQuad(s.mode, s.bufMode));
    COV_SCAN_END: cover property (convEndIrq && isScan(s.mode) && s.mode[1]);
    COV_ABORT: cover property (convAbort);
    COV_CONT_SCAN_WRAP: cover property (convEndIrq && isScan(s.mode) && !s.mode[1]);
    COV_QUAD_REGROUP: cover property (convEndIrq && isQuad(s.mode, s.bufMode) && !s.mode[1]);
endmodule : asts_sequencer

// >>> sim/asts_core_model.sv
`timescale 1ns/1ps
module asts_core_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic convStart,
    input wire logic convAbort,
    input wire logic [2:0] convChannel,
    output logic convDone,
    output logic [9:0] convData
);
    logic busy = 0;
    logic [2:0] ch = 0;
    logic [6:0] seq = 0;
    int left = 0;
    initial convDone = 0;
    initial convData = 0;
    // data toggles between results so a stale sample never matches
    always @(posedge ref_clk) begin
        convDone <= busy && left == 1 && !convAbort;
        convData <= (busy && left == 1) ? {ch, seq} : ~convData;
        if (reset || convAbort || (busy && left == 1)) busy <= 0;
        else if (convStart) begin
            busy <= 1;
            ch <= convChannel;
            left <= slow ? $urandom_range(20, 30) : $urandom_range(1, 4);
        end else if (busy) left <= left - 1;
        if (busy && left == 1) seq <= seq + 1;
    end
endmodule : asts_core_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %0h want %0h", $time, (a), (e)); end end
module tb_top;
    import asts_pkg::*;
    logic ref_clk = 0, reset = 1, regWr = 0, regRd = 0, slow = 0;
    logic [7:0] regAddr = 0;
    logic [31:0] regWdata = 0, rdv, regRdata;
    logic convStart, convAbort, convDone, convEndIrq, convActive;
    logic [2:0] convChannel;
    logic [9:0] convData;
    logic [2:0] chq[$];
    logic [9:0] dq[$];
    logic [31:0] expRes[8];
    int mismatches = 0, compares = 0, cyc = 0;
    asts_sequencer #(.RES_W(10)) dut (.ref_clk, .reset, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .convStart, .convAbort, .convChannel, .convDone, .convData,
        .convEndIrq, .convActive);
    asts_core_model core (.ref_clk, .reset, .slow, .convStart, .convAbort, .convChannel,
        .convDone, .convData);
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (convStart) chq.push_back(convChannel);
        if (convDone) dq.push_back(convData);
        if (cyc == 60000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        regRd <= 1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 0;
        #1 rdv = regRdata;
    endtask : rd
    function automatic int seqLen(input logic [1:0] m, input logic b, input logic [2:0] c);
        return m[0] ? c + 1 : (b ? 4 : 1);
    endfunction : seqLen
    // scan walks 0..c, select always converts c itself
    function automatic int expChan(input logic [1:0] m, input logic [2:0] c, input int j);
        return m[0] ? j % (c + 1) : c;
    endfunction : expChan
    // four-buffer fills slots in order, one-buffer lands on the input's own slot
    function automatic int expSlot(input logic [1:0] m, input logic b, input logic [2:0] c,
                                   input int j);
        return m[0] ? j % (c + 1) : (b ? j % 4 : c);
    endfunction : expSlot
    task automatic run(input logic [1:0] m, input logic b, input logic [2:0] c,
                       input int nirq, input bit ab);
        int len, n, irqs, slot, k;
        len = seqLen(m, b, c);
        chq = {};
        dq = {};
        irqs = 0;
        k = 0;
        slow <= ab || $urandom_range(0, 1);
        wr(ADDR_CHAN_SEL, 32'(c));
        wr(ADDR_MODE_CTRL2, 32'(b));
        wr(ADDR_MODE_CTRL0, {28'h0, m, 2'b01});
        if (ab) begin
            while (chq.size() == 0 && k < 100) begin tick(1); k++; end
            wr(ADDR_CHAN_SEL, 32'(c));
            #1;
            while (!convAbort && k < 200) begin tick(1); k++; end
            `CHK(convAbort, 1'b1)
            chq = {};
            dq = {};
        end
        while (irqs < nirq && k < 3000) begin
            tick(1);
            k++;
            if (convEndIrq) irqs++;
            else `CHK(convActive, 1'b1)
        end
        `CHK(dq.size(), nirq * len)
        if (!m[1]) wr(ADDR_MODE_CTRL0, {28'h0, m, 2'b00});
        tick(3);
        `CHK(convActive, 1'b0)
        n = chq.size();
        tick(20);
        `CHK(chq.size(), n)
        rd(ADDR_MODE_CTRL0);
        `CHK(rdv, {28'h0, m, 2'b00})
        rd(ADDR_MODE_CTRL2);
        `CHK(rdv, 32'(b))
        rd(ADDR_CHAN_SEL);
        `CHK(rdv, 32'(c))
        for (int j = 0; j < nirq * len; j++) begin
            slot = expSlot(m, b, c, j);
            `CHK(chq[j], expChan(m, c, j))
            expRes[slot] = {22'h0, dq[j]};
        end
        for (int r = 0; r < NUM_RESULTS; r++) begin
            rd(ADDR_RESULT_BASE + 8'(4 * r));
            `CHK(rdv, expRes[r])
        end
    endtask : run
    initial begin
        void'($urandom(32'h2057A2B0));
        for (int i = 0; i < 8; i++) expRes[i] = 0;
        repeat (12) @(posedge ref_clk);
        reset <= 0;
        // result slots are read-only, so this write must vanish
        wr(ADDR_RESULT_BASE, 32'hFFFFFFFF);
        for (int a = 0; a < 48; a += 4) begin
            rd(8'(a));
            `CHK(rdv, 32'h0)
        end
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            run(2'(i / 2), 1'(i % 2), 3'($urandom_range(0, 7)), i < 4 ? 2 : 1, 0);
            $display("mode test %0d done", i);
        end
        run(MODE_ONESHOT_SCAN, 1'b0, 3'h3, 1, 1);
        $display("abort test done");
        give_verdict();
    end
endmodule : tb_top
